// ===== core/bpd_defines.svh
`ifndef BPD_DEFINES_SVH
`define BPD_DEFINES_SVH

// clock and reference rates
`define BPD_CLK_PERIOD_NS 8
`define BPD_CLK_MHZ 125
`define BPD_REF_MHZ 1
`define BPD_REF_DIV (`BPD_CLK_MHZ / `BPD_REF_MHZ)

// marker pulse width, rounded up to whole cycles
`define BPD_MARK_NS 600
`define BPD_MARK_CYC ((`BPD_MARK_NS + `BPD_CLK_PERIOD_NS - 1) / `BPD_CLK_PERIOD_NS)

// counter widths and channel layout
`define BPD_CNT_W 13
`define BPD_PRE_W 4
`define BPD_DISC_N 2
`define BPD_NCHAN 9
`define BPD_SYNC_CHAN 8
`define BPD_CYC_W 8

`endif

// ===== core/bpd_marker.sv
`timescale 1ns/1ps
`include "bpd_defines.svh"
module bpd_marker
   import bpd_pkg::*;
(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic SIG_IN,
   output logic EDGE,
   output logic MARK
);
   bpd_mark_s r_ff;
   bpd_mark_s nxt_r;
   localparam logic [6:0] MARK_LAST = 7'(`BPD_MARK_CYC - 1);

   // two-stage synchroniser, then edge detect on the settled stages
   always_comb begin
      nxt_r = r_ff;
      nxt_r.s1 = SIG_IN;
      nxt_r.s2 = r_ff.s1;
      nxt_r.s3 = r_ff.s2;
      nxt_r.edge_p = r_ff.s2 & ~r_ff.s3;
      // fixed-width marker; an edge inside a marker is not restretched
      if (r_ff.mark) begin
         if (r_ff.cnt == 7'h00) begin
            nxt_r.mark = 1'b0;
         end else begin
            nxt_r.cnt = r_ff.cnt - 7'h01;
         end
      end else if (r_ff.s2 & ~r_ff.s3) begin
         nxt_r.mark = 1'b1;
         nxt_r.cnt = MARK_LAST;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign EDGE = r_ff.edge_p;
   assign MARK = r_ff.mark;

   a_mark_width: assert property (@(posedge CLK) disable iff (!ARST_N)
      $rose(r_ff.mark) |-> ##74 r_ff.mark ##1 !r_ff.mark)
      else $error("marker width is not 0.6 us");

   a_edge_single: assert property (@(posedge CLK) disable iff (!ARST_N)
      r_ff.edge_p |=> !r_ff.edge_p)
      else $error("edge pulse longer than one cycle");
endmodule : bpd_marker

// ===== core/bpd_pkg.sv
package bpd_pkg;
   `include "bpd_defines.svh"

   typedef logic [`BPD_NCHAN-1:0][`BPD_CNT_W-1:0] bpd_lim_t;

   // operator configuration
   typedef struct packed {
      logic use_pre;
      logic [1:0] pre_sel;
      logic [2:0] cyc_sel;
      logic [2:0] scale_sel;
      bpd_lim_t lo_lim;
      bpd_lim_t hi_lim;
   } bpd_cfg_s;

   // recognition results
   typedef struct packed {
      logic [`BPD_NCHAN-1:0] chan;
      logic [2:0] code;
      logic code_ok;
      logic err;
   } bpd_res_s;

   typedef enum logic [3:0] {
      BPD_IDLE = 4'h1,
      BPD_DISCARD = 4'h2,
      BPD_COUNT = 4'h4,
      BPD_SAMPLE = 4'h8
   } bpd_state_e;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic edge_p;
      logic mark;
      logic [6:0] cnt;
   } bpd_mark_s;

   typedef struct packed {
      bpd_state_e st;
      logic busy;
      logic [6:0] ref_div;
      logic ref_tick;
      logic [1:0] disc;
      logic [`BPD_CYC_W-1:0] cyc;
      logic [`BPD_PRE_W-1:0] pre;
      logic [`BPD_CNT_W-1:0] per;
      logic [`BPD_NCHAN-1:0] lo;
      logic [`BPD_NCHAN-1:0] hi;
      logic samp;
      bpd_res_s res;
   } bpd_core_s;
endpackage : bpd_pkg

// ===== core/bpd_top.sv
`timescale 1ns/1ps
`include "bpd_defines.svh"
// Behaviour
// - one 0.6 us marker pulse per rising edge of the conditioned input.
// - period measured by counting 1 MHz reference ticks between markers.
// - two-bit counter discards the first two markers of each burst.
// - gate stays open for exactly the selected number of input cycles.
// - accumulated count over selected cycles gives mean period in microseconds.
// - 13-bit period counter, selectable output bits scale to one cycle.
// - eighteen limit flags, an upper and lower pair per channel.
// - a limit flag sets once the count passes its threshold, then stays.
// - one sample pulse samples all limit flags when counting ends.
// - channel flag set only when lower passed and upper not; else unchanged.
// - channel eight is sync, channels zero to seven are data.
// - optional four-bit prescaler divides reference by 2, 4, 8 or 16.
// - configuration picks prescaling, limits and cycle count; device honours it.
// - error flag when the burst lies outside every channel band.
// - data channel flags encoded as a three-bit binary value.
module bpd_top
   import bpd_pkg::*;
#(
   parameter int CNT_W = `BPD_CNT_W,
   parameter int NCHAN = `BPD_NCHAN
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic SUB_IN,
   input wire logic START,
   input wire bpd_cfg_s CFG,
   output logic MARKER,
   output logic BUSY,
   output logic SAMPLE,
   output logic [NCHAN-1:0] LO_FLAGS,
   output logic [NCHAN-1:0] HI_FLAGS,
   output bpd_res_s RESULT
);
   localparam logic [6:0] REF_LAST = 7'(`BPD_REF_DIV - 1);
   localparam logic [1:0] DISC_LAST = 2'(`BPD_DISC_N);

   bpd_core_s r_ff;
   bpd_core_s nxt_r;
   logic edge_p;

   // input conditioning and marker generation
   bpd_marker u_marker (
      .CLK(CLK),
      .ARST_N(ARST_N),
      .SIG_IN(SUB_IN),
      .EDGE(edge_p),
      .MARK(MARKER)
   );

   // thresholds passed by the scaled count, shared by both limit banks
   function automatic logic [NCHAN-1:0] over(input logic [CNT_W-1:0] val, input bpd_lim_t lim);
      logic [NCHAN-1:0] o;
      o = '0;
      for (int i = 0; i < NCHAN; i++) begin
         o[i] = val > lim[i];
      end
      return o;
   endfunction : over

   logic [CNT_W-1:0] scaled;
   logic [3:0] pre_mask;
   logic cnt_tick;
   logic [8:0] cyc_target;
   logic [NCHAN-1:0] lo_now;
   logic [NCHAN-1:0] hi_now;
   logic [NCHAN-1:0] in_band;
   logic [NCHAN-1:0] chan_new;

   // period scaling and clock selection
   always_comb begin
      scaled = r_ff.per >> CFG.scale_sel;
      pre_mask = 4'hF >> (2'h3 - CFG.pre_sel);
      // prescaled tick fires when the selected stage and those below roll over
      cnt_tick = r_ff.ref_tick & (~CFG.use_pre | (&(r_ff.pre | ~pre_mask)));
      cyc_target = 9'h001 << CFG.cyc_sel;
      lo_now = r_ff.lo | over(scaled, CFG.lo_lim);
      hi_now = r_ff.hi | over(scaled, CFG.hi_lim);
      in_band = lo_now & ~hi_now;
      chan_new = r_ff.res.chan | in_band;
   end

   // sequencing, counting and recognition
   always_comb begin
      nxt_r = r_ff;
      nxt_r.samp = 1'b0;
      // free-running 1 MHz reference derived from the system clock
      nxt_r.ref_tick = 1'b0;
      if (r_ff.ref_div == REF_LAST) begin
         nxt_r.ref_div = 7'h00;
         nxt_r.ref_tick = 1'b1;
      end else begin
         nxt_r.ref_div = r_ff.ref_div + 7'h01;
      end
      if (START) begin
         // restart wins over any analysis in flight
         nxt_r.st = BPD_DISCARD;
         nxt_r.disc = 2'h0;
         nxt_r.cyc = '0;
         nxt_r.per = '0;
         nxt_r.pre = '0;
         nxt_r.lo = '0;
         nxt_r.hi = '0;
         nxt_r.res = '0;
      end else begin
         case (r_ff.st)
            BPD_IDLE: begin
               nxt_r.st = BPD_IDLE;
            end
            BPD_DISCARD: begin
               // first two markers may be partial cycles; the third opens the gate
               if (edge_p) begin
                  if (r_ff.disc == DISC_LAST) begin
                     nxt_r.st = BPD_COUNT;
                  end else begin
                     nxt_r.disc = r_ff.disc + 2'h1;
                  end
               end
            end
            BPD_COUNT: begin
               // gate open: reference reaches the counters
               if (r_ff.ref_tick) begin
                  nxt_r.pre = r_ff.pre + 4'h1;
               end
               // saturate so a slow burst cannot wrap back into a band
               if (cnt_tick && !(&r_ff.per)) begin
                  nxt_r.per = r_ff.per + 13'(1);
               end
               nxt_r.lo = lo_now;
               nxt_r.hi = hi_now;
               if (edge_p) begin
                  nxt_r.cyc = r_ff.cyc + 8'h01;
                  if (9'(r_ff.cyc) + 9'h001 == cyc_target) begin
                     nxt_r.st = BPD_SAMPLE;
                  end
               end
            end
            BPD_SAMPLE: begin
               // one sample pulse looks at all eighteen flags at once
               nxt_r.lo = lo_now;
               nxt_r.hi = hi_now;
               nxt_r.samp = 1'b1;
               nxt_r.res.chan = chan_new;
               nxt_r.res.err = ~|in_band;
               nxt_r.res.code_ok = 1'b0;
               nxt_r.res.code = 3'h0;
               // lowest data channel wins; sync channel carries no code
               for (int i = `BPD_SYNC_CHAN - 1; i >= 0; i--) begin
                  if (chan_new[i]) begin
                     nxt_r.res.code = 3'(i);
                     nxt_r.res.code_ok = 1'b1;
                  end
               end
               nxt_r.st = BPD_IDLE;
            end
            default: begin
               nxt_r.st = BPD_IDLE;
            end
         endcase
      end
      nxt_r.busy = (nxt_r.st != BPD_IDLE);
   end

   // state register
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         r_ff <= '0;
         r_ff.st <= BPD_IDLE;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign BUSY = r_ff.busy;
   assign SAMPLE = r_ff.samp;
   assign LO_FLAGS = r_ff.lo;
   assign HI_FLAGS = r_ff.hi;
   assign RESULT = r_ff.res;

   // checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);

   a_disc_two: assert property (
      (r_ff.st == BPD_DISCARD && !START && edge_p && r_ff.disc == 2'h2) |=> r_ff.st == BPD_COUNT)
      else $error("count did not start after two discarded markers");

   a_disc_early: assert property (
      (r_ff.st == BPD_DISCARD && !START && edge_p && r_ff.disc == 2'h1) |=> r_ff.st == BPD_DISCARD)
      else $error("counting started before two markers were discarded");

   a_gate_only: assert property (
      (r_ff.per != $past(r_ff.per) && !$past(START)) |-> $past(r_ff.st) == BPD_COUNT)
      else $error("period counter moved outside the gate");

   a_ref_tick: assert property (
      (r_ff.per != $past(r_ff.per) && !$past(START)) |-> $past(r_ff.ref_tick))
      else $error("period counter moved without a reference tick");

   a_sample_once: assert property (
      (r_ff.st == BPD_SAMPLE && !START) |=> r_ff.samp ##1 !r_ff.samp)
      else $error("sample pulse missing or stretched");

   a_flag_sticky: assert property (
      !START |=> ((~r_ff.lo & $past(r_ff.lo)) == '0 && (~r_ff.hi & $past(r_ff.hi)) == '0))
      else $error("limit flag dropped without a start");

   a_chan_band: assert property (
      r_ff.samp |-> ((r_ff.res.chan & ~$past(r_ff.res.chan) & ~(r_ff.lo & ~r_ff.hi)) == '0))
      else $error("channel set outside its band");

   a_err_band: assert property (
      r_ff.samp |-> r_ff.res.err == ((r_ff.lo & ~r_ff.hi) == '0))
      else $error("error flag disagrees with the bands");

   a_code_match: assert property (
      r_ff.res.code_ok |-> r_ff.res.chan[r_ff.res.code])
      else $error("binary code does not name a set channel");

   a_start_clear: assert property (
      START |=> (r_ff.per == '0 && r_ff.lo == '0 && r_ff.hi == '0 && r_ff.cyc == '0 && r_ff.pre == '0))
      else $error("start did not clear the counters");

   a_chan_hold: assert property (
      (!r_ff.samp && !$past(START)) |-> r_ff.res.chan == $past(r_ff.res.chan))
      else $error("channel flags changed between samples");

   a_res_hold: assert property (
      (!r_ff.samp && !$past(START)) |-> r_ff.res == $past(r_ff.res))
      else $error("result changed between samples");

   a_ref_align: assert property (
      r_ff.ref_tick |-> r_ff.ref_div == 7'h00)
      else $error("reference tick off its divider phase");

   a_ref_gap: assert property (
      r_ff.ref_tick |=> !r_ff.ref_tick [*8])
      else $error("reference ticks too close together");

   a_per_step: assert property (
      !$past(START) |-> (r_ff.per == $past(r_ff.per) || r_ff.per == $past(r_ff.per) + 13'h0001))
      else $error("period counter jumped by more than one");

   a_per_direct: assert property (
      (r_ff.st == BPD_COUNT && r_ff.ref_tick && !CFG.use_pre && !(&r_ff.per) && !START)
      |=> r_ff.per == $past(r_ff.per) + 13'h0001)
      else $error("direct clocking missed a reference tick");

   a_pre_hold: assert property (
      (r_ff.st == BPD_COUNT && r_ff.ref_tick && CFG.use_pre && !r_ff.pre[0] && !START)
      |=> r_ff.per == $past(r_ff.per))
      else $error("prescaled count advanced on a skipped tick");

   a_pre_step: assert property (
      (r_ff.st == BPD_COUNT && r_ff.ref_tick && !START) |=> r_ff.pre == $past(r_ff.pre) + 4'h1)
      else $error("prescaler missed a reference tick");

   a_pre_idle: assert property (
      (r_ff.st != BPD_COUNT && !START) |=> r_ff.pre == $past(r_ff.pre))
      else $error("prescaler moved outside the gate");

   a_per_sat: assert property (
      (&r_ff.per && !START) |=> &r_ff.per)
      else $error("period counter wrapped");

   // each limit flag may only rise once the scaled count has passed its threshold
   for (genvar g = 0; g < NCHAN; g++) begin : g_lim_chk
      a_lo_cause: assert property (
         (r_ff.lo[g] && !$past(r_ff.lo[g]) && !$past(START)) |-> $past(scaled) > $past(CFG.lo_lim[g]))
         else $error("lower limit flag set below its threshold");

      a_hi_cause: assert property (
         (r_ff.hi[g] && !$past(r_ff.hi[g]) && !$past(START)) |-> $past(scaled) > $past(CFG.hi_lim[g]))
         else $error("upper limit flag set below its threshold");
   end : g_lim_chk

   a_cyc_close: assert property (
      r_ff.st == BPD_SAMPLE |-> 9'(r_ff.cyc) == cyc_target)
      else $error("gate closed on the wrong cycle count");

   a_cyc_limit: assert property (
      r_ff.st == BPD_COUNT |-> 9'(r_ff.cyc) < cyc_target)
      else $error("gate stayed open past the cycle count");

   a_idle_quiet: assert property (
      (r_ff.st == BPD_IDLE && !START) |=> (!r_ff.samp && r_ff.st == BPD_IDLE))
      else $error("sample pulse without an analysis");

   a_busy_start: assert property (
      START |=> r_ff.busy)
      else $error("start did not raise busy");

   a_sync_nocode: assert property (
      (r_ff.samp && r_ff.res.chan[7:0] == 8'h00) |-> !r_ff.res.code_ok)
      else $error("code given without a data channel");

   a_code_full: assert property (
      (r_ff.samp && r_ff.res.chan[7:0] != 8'h00) |-> r_ff.res.code_ok)
      else $error("data channel set but no code given");

   a_code_lowest: assert property (
      r_ff.res.code_ok |-> (r_ff.res.chan[7:0] & ((8'h01 << r_ff.res.code) - 8'h01)) == 8'h00)
      else $error("code does not name the lowest data channel");

   c_data_hit: cover property (r_ff.samp && r_ff.res.code_ok);
   c_sync_hit: cover property (r_ff.samp && r_ff.res.chan[`BPD_SYNC_CHAN]);
   c_error: cover property (r_ff.samp && r_ff.res.err);
   c_prescaled: cover property (CFG.use_pre && r_ff.samp);
endmodule : bpd_top

// ===== verification/bpd_src.sv
`timescale 1ns/1ps
// squared subcarrier source; idles low between bursts
module bpd_src (
   input wire logic en,
   input wire logic [15:0] per_ns,
   output logic sig
);
   // one small offset per burst keeps edges off the clock grid without stretching the period
   initial begin
      sig = 1'b0;
      forever begin
         wait (en);
         #3;
         while (en) begin
            sig = 1'b1;
            #(per_ns / 2) sig = 1'b0;
            #(per_ns - per_ns / 2);
         end
      end
   end
endmodule : bpd_src

// ===== verification/bpd_top_tb.sv
`timescale 1ns/1ps
module bpd_top_tb;
   import bpd_pkg::*;
   logic clk, arst_n, start, sub_in, marker, busy, sample, src_en;
   logic [15:0] per_ns;
   logic [8:0] lo_flags, hi_flags, pchan;
   bpd_cfg_s cfg;
   bpd_res_s result, er;
   bpd_res_s expq[$];
   int ekq[$];
   int failures = 0, checks = 0, cycles = 0, nsamp = 0, mk = 0, ek, seed;

   bpd_top u_bpd_top (.CLK(clk), .ARST_N(arst_n), .SUB_IN(sub_in), .START(start), .CFG(cfg),
      .MARKER(marker), .BUSY(busy), .SAMPLE(sample), .LO_FLAGS(lo_flags), .HI_FLAGS(hi_flags),
      .RESULT(result));
   bpd_src u_bpd_src (.en(src_en), .per_ns(per_ns), .sig(sub_in));

   // 8 ns clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   // ceiling leaves headroom over the roughly 80k cycles the bursts need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 115000) begin
         failures++;
         close_out();
      end
   end

   // marker width measured on every pulse, mid-cycle away from the launching edge
   always @(negedge clk) begin
      if (marker === 1'b1) begin
         mk++;
      end else if (mk != 0) begin
         check("marker", mk, 32'h4B);
         mk = 0;
      end
   end

   // each sample pulse is judged against the oldest noted expectation, mid-cycle
   always @(negedge clk) begin
      if (sample === 1'b1) begin
         nsamp++;
         if (expq.size() == 0) begin
            check("sample", 1'h1, 1'h0);
         end else begin
            er = expq.pop_front();
            ek = ekq.pop_front();
            check("chan", result.chan, er.chan);
            check("err", result.err, er.err);
            check("code_ok", result.code_ok, er.code_ok);
            if (er.code_ok) check("code", result.code, er.code);
            check("lo", lo_flags, 9'h1FF);
            check("hi", hi_flags, (ek < 9) ? 9'(~(9'h001 << ek)) : 9'h1FF);
            check("busy", busy, 1'h0);
         end
      end
   end

   // one burst: channel k in band around p per cycle, others out of band
   task automatic run(input int k, input int p, input logic [2:0] n, input logic [2:0] s,
         input logic [2:0] pre);
      bpd_res_s r;
      int t;
      check("hold", result.chan, pchan);
      cfg.use_pre = pre[2];
      cfg.pre_sel = pre[1:0];
      cfg.cyc_sel = n;
      cfg.scale_sel = s;
      for (int i = 0; i < 9; i++) begin
         cfg.lo_lim[i] = 13'h0000;
         cfg.hi_lim[i] = 13'h0000;
      end
      if (k < 9) begin
         cfg.lo_lim[k] = 13'(p - 3);
         cfg.hi_lim[k] = 13'(p + 2);
      end
      r.chan = (k < 9) ? 9'(1 << k) : 9'h000;
      r.code = 3'(k);
      r.code_ok = (k < 8);
      r.err = (k > 8);
      expq.push_back(r);
      ekq.push_back(k);
      per_ns = 16'(p * 1000);
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      check("clr_lo", lo_flags, 9'h000);
      check("clr_chan", result.chan, 9'h000);
      check("run", busy, 1'h1);
      t = nsamp;
      src_en = 1'b1;
      wait (nsamp != t);
      src_en = 1'b0;
      // let the source finish its cycle before the next burst
      repeat (1500) @(negedge clk);
      pchan = r.chan;
      $display("test done channel %0d", k);
   endtask : run

   initial begin
      seed = 11442;
      arst_n = 1'b0;
      start = 1'b0;
      src_en = 1'b0;
      per_ns = 16'h1F40;
      pchan = 9'h000;
      cfg = '0;
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      // direct clocking with random period, then each prescale ratio
      for (int k = 0; k < 8; k++) begin
         if (k < 4) begin
            run(k, 8 + ($unsigned($random(seed)) % 4), 3'h1, 3'h1, 3'h0);
         end else begin
            run(k, 8, 3'(k - 3), 3'h0, 3'(k));
         end
      end
      run(8, 9, 3'h1, 3'h1, 3'h0);
      run(9, 8, 3'h1, 3'h1, 3'h0);
      close_out();
   end
endmodule : bpd_top_tb
